// ==== logic/dsf_sense.sv ====
// Sense byte collection for the disk attachment, APB slave
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
module dsf_sense #(
  // Number of sense bytes held; the packed carrier fixes it
  parameter int SENSE_BYTES = `DSF_SENSE_BYTES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sense state
  output logic             unit_check,
  output logic             sense_valid
);
  // Refuse a sense depth other than the one the carrier holds
  if (SENSE_BYTES != `DSF_SENSE_BYTES) begin : g_bad_sense_bytes
    $error("sense byte count must match the carrier");
  end

  // Register state
  dsf_pkg::dsf_sense_t sense, next_sense;
  dsf_pkg::dsf_state_t state, next_state;
  logic [1:0]  flag, next_flag;
  logic [7:0]  mask, next_mask;
  logic [3:0]  fstat, next_fstat;
  logic        seen_mark, next_seen_mark;
  logic        idx_armed, next_idx_armed;
  logic        cnt_have, next_cnt_have;
  logic        cnt_last, next_cnt_last;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_unit_check, next_sense_valid;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : hit

  // Access phase of a write or read
  logic wr, rd;
  logic [31:0] ev;
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;
  assign ev = (wr && hit(paddr, `DSF_ADDR_EVENT)) ? pwdata : 32'h0000_0000;

  // Next sense state
  always_comb begin
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic       start;
    logic       acc;
    // Command start and file access decode, set first
    start = wr && hit(paddr, `DSF_ADDR_CMD) && pwdata[`DSF_CMD_START];
    acc = start && pwdata[`DSF_CMD_ACCESS];
    b0 = sense.b0;
    b1 = sense.b1;
    b2 = sense.b2;
    next_sense = sense;
    next_state = state;
    next_flag = flag;
    next_mask = mask;
    next_fstat = fstat;
    next_seen_mark = seen_mark;
    next_idx_armed = idx_armed;
    next_cnt_have = cnt_have;
    next_cnt_last = cnt_last;
    // A new non-sense command drops the old sense bytes
    if (start && !pwdata[`DSF_CMD_SENSE]) begin
      b0 = 8'h00;
      b1 = 8'h00;
      b2 = 8'h00;
      next_state = dsf_pkg::DSF_ACTIVE;
      next_idx_armed = 1'b0;
      next_cnt_have = 1'b0;
      next_seen_mark = 1'b0;
    end
    if (wr && hit(paddr, `DSF_ADDR_FLAG)) next_flag = pwdata[1:0];
    if (wr && hit(paddr, `DSF_ADDR_MASK)) next_mask = pwdata[7:0];
    if (wr && hit(paddr, `DSF_ADDR_STATUS)) next_fstat = pwdata[3:0];
    // Command checks at start
    if (ev[`DSF_EV_BAD_CMD]) b0[`DSF_S0_CMD_REJ] = 1'b1;
    if (ev[`DSF_EV_BAD_SEEK]) begin
      b0[`DSF_S0_CMD_REJ] = 1'b1;
      b0[`DSF_S0_SEEK] = 1'b1;
    end
    if (ev[`DSF_EV_BAD_SEQ]) begin
      b0[`DSF_S0_CMD_REJ] = 1'b1;
      b1[`DSF_S1_SEQ] = 1'b1;
    end
    if (start && pwdata[`DSF_CMD_WRITE] && mask[`DSF_MASK_INH_WR]) begin
      b0[`DSF_S0_CMD_REJ] = 1'b1;
      b1[`DSF_S1_PROTECT] = 1'b1;
    end
    if (acc && !(fstat[`DSF_ST_ONLINE] && fstat[`DSF_ST_USABLE]))
      b0[`DSF_S0_INTV] = 1'b1;
    // Equipment check causes
    if (ev[`DSF_EV_UNSAFE]) b2[`DSF_S2_UNSAFE] = 1'b1;
    if (ev[`DSF_EV_CYCLIC]) b2[`DSF_S2_CYCLIC] = 1'b1;
    if (ev[`DSF_EV_CONTRA]) b2[`DSF_S2_SEL_STAT] = 1'b1;
    if (fstat[`DSF_ST_STATUS] && !fstat[`DSF_ST_SELECTED])
      b2[`DSF_S2_UNSEL] = 1'b1;
    if (b2[`DSF_S2_UNSAFE] | b2[`DSF_S2_CYCLIC] | b2[`DSF_S2_SEL_STAT]
        | b2[`DSF_S2_UNSEL])
      b0[`DSF_S0_EQUIP] = 1'b1;
    // Data errors
    if (ev[`DSF_EV_DATA_ERR]) b0[`DSF_S0_DATA] = 1'b1;
    if (ev[`DSF_EV_CNT_ERR]) begin
      b0[`DSF_S0_DATA] = 1'b1;
      b1[`DSF_S1_CNT_DATA] = 1'b1;
    end
    // Missing address marker tracking
    if (ev[`DSF_EV_ADDR_MARK]) next_seen_mark = 1'b1;
    if (ev[`DSF_EV_INDEX]) begin
      if (idx_armed && !seen_mark && !ev[`DSF_EV_ADDR_MARK])
        b1[`DSF_S1_MISS_AM] = 1'b1;
      next_idx_armed = 1'b1;
      next_seen_mark = 1'b0;
    end
    if (ev[`DSF_EV_COUNT]) begin
      if (cnt_have && cnt_last == ev[`DSF_EV_CNT_FLAG])
        b1[`DSF_S1_MISS_AM] = 1'b1;
      next_cnt_have = 1'b1;
      next_cnt_last = ev[`DSF_EV_CNT_FLAG];
    end
    if (ev[`DSF_EV_STARVE] || ev[`DSF_EV_LATE]) b0[`DSF_S0_OVERRUN] = 1'b1;
    if (acc && flag[`DSF_FLAG_DEFECT] && !pwdata[`DSF_CMD_HDR_R0])
      b0[`DSF_S0_TRACK] = 1'b1;
    if (ev[`DSF_EV_MT_CHAIN] && flag[`DSF_FLAG_ALT]) b0[`DSF_S0_TRACK] = 1'b1;
    if (ev[`DSF_EV_SEEK_FAIL]) b0[`DSF_S0_SEEK] = 1'b1;
    next_sense.b0 = b0;
    next_sense.b1 = b1;
    next_sense.b2 = b2;
    next_sense.b3 = {4'h0, fstat};
    next_sense.b4 = 8'h00;
    next_sense.b5 = {6'h00, flag};
    // Sense command returns bytes, then clears bytes 0 to 2 on the next read of the high sense word
    if (start && pwdata[`DSF_CMD_SENSE]) next_state = dsf_pkg::DSF_SENSED;
    if (rd && hit(paddr, `DSF_ADDR_SENSE_H) && state == dsf_pkg::DSF_SENSED) begin
      next_sense.b0 = 8'h00;
      next_sense.b1 = 8'h00;
      next_sense.b2 = 8'h00;
      next_state = dsf_pkg::DSF_IDLE;
    end
  end

  // APB answers
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    next_unit_check = |{next_sense.b0, next_sense.b1, next_sense.b2};
    next_sense_valid = next_state == dsf_pkg::DSF_SENSED;
    if (rd) begin
      unique case (paddr)
        `DSF_ADDR_CMD:     next_prdata = {30'h0, state};
        `DSF_ADDR_EVENT:   next_prdata = 32'h0000_0000;
        `DSF_ADDR_FLAG:    next_prdata = {30'h0, flag};
        `DSF_ADDR_MASK:    next_prdata = {24'h0, mask};
        `DSF_ADDR_SENSE_L: next_prdata = sense[31:0];
        `DSF_ADDR_SENSE_H: next_prdata = {16'h0, sense[47:32]};
        `DSF_ADDR_STATUS:  next_prdata = {28'h0, fstat};
        default:           next_pslverr = 1'b1;
      endcase
    end else if (wr && !(hit(paddr, `DSF_ADDR_CMD) || hit(paddr, `DSF_ADDR_EVENT)
               || hit(paddr, `DSF_ADDR_FLAG) || hit(paddr, `DSF_ADDR_MASK)
               || hit(paddr, `DSF_ADDR_STATUS))) begin
      next_pslverr = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense       <= '0;
      state       <= dsf_pkg::DSF_IDLE;
      flag        <= 2'h0;
      mask        <= 8'h00;
      fstat       <= 4'h0;
      seen_mark   <= 1'b0;
      idx_armed   <= 1'b0;
      cnt_have    <= 1'b0;
      cnt_last    <= 1'b0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      unit_check  <= 1'b0;
      sense_valid <= 1'b0;
    end else begin
      sense       <= next_sense;
      state       <= next_state;
      flag        <= next_flag;
      mask        <= next_mask;
      fstat       <= next_fstat;
      seen_mark   <= next_seen_mark;
      idx_armed   <= next_idx_armed;
      cnt_have    <= next_cnt_have;
      cnt_last    <= next_cnt_last;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
      unit_check  <= next_unit_check;
      sense_valid <= next_sense_valid;
    end
  end
endmodule : dsf_sense
`default_nettype wire

// ==== logic/dsf_defines.svh ====
// Constants for the disk sense and track flag block
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH
// Register byte addresses
`define DSF_ADDR_CMD     12'h000
`define DSF_ADDR_EVENT   12'h004
`define DSF_ADDR_FLAG    12'h008
`define DSF_ADDR_MASK    12'h00C
`define DSF_ADDR_SENSE_L 12'h010
`define DSF_ADDR_SENSE_H 12'h014
`define DSF_ADDR_STATUS  12'h018
// Sense byte 0 bits
`define DSF_S0_CMD_REJ   0
`define DSF_S0_INTV      1
`define DSF_S0_EQUIP     3
`define DSF_S0_DATA      4
`define DSF_S0_OVERRUN   5
`define DSF_S0_TRACK     6
`define DSF_S0_SEEK      7
// Sense byte 1 bits
`define DSF_S1_CNT_DATA  0
`define DSF_S1_SEQ       3
`define DSF_S1_PROTECT   5
`define DSF_S1_MISS_AM   6
// Sense byte 2 bits
`define DSF_S2_UNSAFE    0
`define DSF_S2_SEL_STAT  3
`define DSF_S2_CYCLIC    4
`define DSF_S2_UNSEL     5
// Event register bits
`define DSF_EV_BAD_CMD   0
`define DSF_EV_BAD_SEEK  1
`define DSF_EV_BAD_SEQ   2
`define DSF_EV_INDEX     3
`define DSF_EV_ADDR_MARK 4
`define DSF_EV_COUNT     5
`define DSF_EV_CNT_FLAG  6
`define DSF_EV_STARVE    7
`define DSF_EV_LATE      8
`define DSF_EV_DATA_ERR  9
`define DSF_EV_CNT_ERR   10
`define DSF_EV_SEEK_FAIL 11
`define DSF_EV_UNSAFE    12
`define DSF_EV_CYCLIC    13
`define DSF_EV_CONTRA    14
`define DSF_EV_MT_CHAIN  15
// Command register bits
`define DSF_CMD_START    0
`define DSF_CMD_SENSE    1
`define DSF_CMD_WRITE    2
`define DSF_CMD_ACCESS   3
`define DSF_CMD_HDR_R0   4
// Track flag register bits
`define DSF_FLAG_DEFECT  0
`define DSF_FLAG_ALT     1
// File status register bits
`define DSF_ST_ONLINE    0
`define DSF_ST_USABLE    1
`define DSF_ST_SELECTED  2
`define DSF_ST_STATUS    3
// Mask bit: inhibit write
`define DSF_MASK_INH_WR  0
`define DSF_SENSE_BYTES  6
`endif

// ==== logic/dsf_pkg.sv ====
// Types for the disk sense and track flag block
`default_nettype none
package dsf_pkg;
  typedef struct packed {
    logic [7:0] b5;
    logic [7:0] b4;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } dsf_sense_t;
  typedef enum logic [1:0] {DSF_IDLE, DSF_ACTIVE, DSF_SENSED} dsf_state_t;
endpackage : dsf_pkg
`default_nettype wire

// ==== verification/dsf_sense_properties.sv ====
// Port checker for the disk sense block
`timescale 1ns/1ps
`default_nettype none
module dsf_sense_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sense state
  input wire logic        unit_check,
  input wire logic        sense_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access edge and sense low read
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence rdl_s;
    acc_s ##0 (!pwrite && paddr == 12'h010);
  endsequence
  ready_once_a: assert property (acc_s |=> pready ##1 !pready)
    else $error("pready not a single pulse");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  unmapped_a: assert property (acc_s ##0 paddr > 12'h018 |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_a: assert property (acc_s ##0 (paddr <= 12'h018 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped access refused");
  equip_sum_a: assert property (rdl_s |=> prdata[3] == (|prdata[23:16]))
    else $error("equipment bit disagrees with cause byte");
  uc_sum_a: assert property (rdl_s |=> unit_check == (|prdata[23:0]))
    else $error("unit check disagrees with sense bytes");
  uc_hold_a: assert property ($fell(unit_check) |-> $past(psel) || $past(psel, 2))
    else $error("unit check dropped without access");
  sv_rise_a: assert property ($rose(sense_valid) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("sense valid without command");
  sv_fall_a: assert property ($fell(sense_valid) |-> $past(psel) || $past(psel, 2))
    else $error("sense valid dropped without access");
endmodule : dsf_sense_properties
bind dsf_sense dsf_sense_properties i_dsf_sense_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_check(unit_check),
  .sense_valid(sense_valid));
`default_nettype wire

// ==== verification/dsf_host_model.sv ====
// Host model issuing APB transfers
`timescale 1ns/1ps
`default_nettype none
module dsf_host_model (
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int hangs;
  // Idle bus at start
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hangs = 0;
  end
  // Setup, then access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hangs++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : dsf_host_model
`default_nettype wire

// ==== verification/test_disk_sense_error_and_track_flagging.sv ====
// Self-checking bench for the disk sense block
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
`define CHK(a, x) begin comparisons++; if ((a) !== (x)) begin miscompares++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (x)); end end
module test_disk_sense_error_and_track_flagging;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, unit_check, sense_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  int          miscompares, comparisons;
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Design and host
  dsf_sense i_dsf_sense (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_check(unit_check), .sense_valid(sense_valid));
  dsf_host_model i_dsf_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Counts and verdict
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // One transfer, hang ends the run
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] wd);
    i_dsf_host_model.xfer(w, a, wd, d, e);
    if (i_dsf_host_model.hangs != 0) begin
      miscompares++;
      summarize();
    end
  endtask : xf
  // Set up, start, raise events, sense and compare
  task automatic run(input logic m, input logic [1:0] f, input logic [3:0] s,
                     input logic [4:0] c, input logic [15:0] e1, e2, input logic [23:0] x);
    xf(1'b1, `DSF_ADDR_MASK, {31'h0, m});
    xf(1'b1, `DSF_ADDR_FLAG, {30'h0, f});
    xf(1'b1, `DSF_ADDR_STATUS, {28'h0, s});
    xf(1'b1, `DSF_ADDR_CMD, {27'h0, c});
    if (e1 != 16'h0) xf(1'b1, `DSF_ADDR_EVENT, {16'h0, e1});
    if (e2 != 16'h0) xf(1'b1, `DSF_ADDR_EVENT, {16'h0, e2});
    xf(1'b1, `DSF_ADDR_CMD, 32'h3);
    `CHK(sense_valid, 1'b1)
    xf(1'b0, `DSF_ADDR_SENSE_L, 32'h0);
    `CHK(d[23:0], x)
    `CHK(d[31:24], {4'h0, s})
    xf(1'b0, `DSF_ADDR_SENSE_H, 32'h0);
    `CHK(d[15:0], {6'h00, f, 8'h00})
    repeat (2) @(posedge pclk);
    `CHK(sense_valid, 1'b0)
  endtask : run
  // Events on a started, ready unit
  task automatic ev(input logic [15:0] e1, e2, input logic [23:0] x);
    run(1'b0, 2'h0, 4'h7, 5'h01, e1, e2, x);
  endtask : ev
  // Reset values, read-write and unmapped
  task automatic t_bus;
    for (int i = 0; i < 7; i++) begin
      xf(1'b0, 12'(i * 4), 32'h0);
      `CHK(d, 32'h0)
    end
    xf(1'b1, 12'h020, 32'hFFFFFFFF);
    `CHK(e, 1'b1)
    xf(1'b0, 12'h020, 32'h0);
    `CHK(d, 32'h0)
    xf(1'b1, `DSF_ADDR_FLAG, 32'h3);
    xf(1'b0, `DSF_ADDR_FLAG, 32'h0);
    `CHK(d, 32'h3)
  endtask : t_bus
  // Command rejects
  task automatic t_reject;
    ev(16'h0001, 16'h0000, 24'h000001);
    ev(16'h0002, 16'h0000, 24'h000081);
    ev(16'h0004, 16'h0000, 24'h000801);
    run(1'b1, 2'h0, 4'h7, 5'h05, 16'h0000, 16'h0000, 24'h002001);
  endtask : t_reject
  // Unit state and equipment causes
  task automatic t_unit;
    run(1'b0, 2'h0, 4'h0, 5'h09, 16'h0000, 16'h0000, 24'h000002);
    run(1'b0, 2'h0, 4'h1, 5'h09, 16'h0000, 16'h0000, 24'h000002);
    ev(16'h1000, 16'h0000, 24'h010008);
    ev(16'h2000, 16'h0000, 24'h100008);
    ev(16'h4000, 16'h0000, 24'h080008);
    run(1'b0, 2'h0, 4'hB, 5'h01, 16'h0000, 16'h0000, 24'h200008);
  endtask : t_unit
  // Media and timing faults
  task automatic t_media;
    ev(16'h0200, 16'h0000, 24'h000010);
    ev(16'h0400, 16'h0000, 24'h000110);
    ev(16'h0008, 16'h0008, 24'h004000);
    ev(16'h0060, 16'h0060, 24'h004000);
    ev(16'h0020, 16'h0060, 24'h000000);
    ev(16'h0080, 16'h0000, 24'h000020);
    ev(16'h0100, 16'h0000, 24'h000020);
    ev(16'h0800, 16'h0000, 24'h000080);
  endtask : t_media
  // Flagged tracks
  task automatic t_track;
    run(1'b0, 2'h1, 4'h7, 5'h09, 16'h0000, 16'h0000, 24'h000040);
    run(1'b0, 2'h1, 4'h7, 5'h19, 16'h0000, 16'h0000, 24'h000000);
    run(1'b0, 2'h2, 4'h7, 5'h01, 16'h8000, 16'h0000, 24'h000040);
    ev(16'h8000, 16'h0000, 24'h000000);
  endtask : t_track
  // Host surface test and track flagging duties
  task automatic t_surface;
    for (int p = 0; p < 1; p++) begin
      run(1'b0, 2'h0, 4'h7, 5'h19, 16'h0000, 16'h0000, 24'h000000);
      run(1'b0, 2'h0, 4'h7, 5'h19, 16'h0000, 16'h0000, 24'h000000);
    end
    ev(16'h0200, 16'h0200, 24'h000010);
    run(1'b0, 2'h1, 4'h7, 5'h1D, 16'h0000, 16'h0000, 24'h000000);
    run(1'b0, 2'h2, 4'h7, 5'h1D, 16'h0000, 16'h0000, 24'h000000);
    run(1'b0, 2'h1, 4'h7, 5'h0D, 16'h0000, 16'h0000, 24'h000040);
  endtask : t_surface
  // Sense kept across other accesses, cleared by a new start
  task automatic t_hold;
    xf(1'b1, `DSF_ADDR_CMD, 32'h1);
    xf(1'b1, `DSF_ADDR_EVENT, 32'h1);
    xf(1'b1, `DSF_ADDR_FLAG, 32'h0);
    xf(1'b0, `DSF_ADDR_CMD, 32'h0);
    `CHK(d[1:0], 2'h1)
    `CHK(unit_check, 1'b1)
    xf(1'b1, `DSF_ADDR_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(unit_check, 1'b0)
  endtask : t_hold
  // Main sequence
  initial begin
    presetn = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_reject();
    t_unit();
    t_media();
    t_track();
    t_surface();
    t_hold();
    summarize();
  end
endmodule : test_disk_sense_error_and_track_flagging
`default_nettype wire
